// ### hw/scw_pkg.sv
// Purpose: shared constants and types for the serial configuration write port
// Assumes: register codes and reset values as the device defines them
// Notes: reset values of registers without a printed default follow their must-be-one bits
package scw_pkg;

  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 12;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 16;
  localparam logic [11:0] HDR_PATTERN = 12'h001;

  // register codes
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_I_OFFSET = 4'h2;
  localparam logic [3:0] ADDR_I_GAIN = 4'h3;
  localparam logic [3:0] ADDR_Q_OFFSET = 4'ha;
  localparam logic [3:0] ADDR_Q_GAIN = 4'hb;
  localparam logic [3:0] ADDR_ILV_ENABLE = 4'hd;
  localparam logic [3:0] ADDR_ILV_COARSE = 4'he;
  localparam logic [3:0] ADDR_ILV_FINE = 4'hf;

  // power-on values
  localparam logic [15:0] RST_CONFIG = 16'hb2ff;
  localparam logic [15:0] RST_OFFSET = 16'h007f;
  localparam logic [15:0] RST_GAIN = 16'h807f;
  localparam logic [15:0] RST_ILV_ENABLE = 16'h3fff;
  localparam logic [15:0] RST_ILV_COARSE = 16'h07ff;
  localparam logic [15:0] RST_ILV_FINE = 16'h007f;

  // configuration field positions
  localparam int CFG_DCS_BIT = 12;
  localparam int CFG_DCP_BIT = 11;
  localparam int CFG_SDR_BIT = 10;
  localparam int CFG_SWING_BIT = 9;
  localparam int CFG_EDGE_BIT = 8;
  localparam int OFS_MAG_LSB = 8;
  localparam int OFS_SIGN_BIT = 7;
  localparam int GAIN_LSB = 7;
  localparam int ILV_EN_BIT = 15;
  localparam int ILV_AUTO_BIT = 14;
  localparam int CRS_INSEL_BIT = 15;
  localparam int CRS_DIR_BIT = 14;
  localparam int CRS_MAG_LSB = 11;
  localparam int FINE_LSB = 7;

  // one decoded write leaving the shifter
  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [15:0] data;
  } scw_write_s;

  // effective output controls
  typedef struct packed {
    logic duty_cycle_stabilize;
    logic ddr_output_phase;
    logic single_rate_select;
    logic output_swing_select;
    logic edge_select;
  } scw_outctl_s;

endpackage

// ### hw/scw_sync.sv
// Purpose: two-stage synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous to clk
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
module scw_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  // two flops, constants under reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

// ### hw/scw_shifter.sv
// Purpose: frame shifter for the serial write link
// Assumes: sclk edge and data level already synchronised to the core clock
// Notes: emits one pulse per complete, header-valid frame
`timescale 1ns/1ps
module scw_shifter
  import scw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic select_n,
  input wire logic sclk_rise,
  input wire logic serial_write_input,
  output scw_write_s wr
);

  logic [31:0] shift_q;
  logic [5:0] count_q;
  logic [31:0] frame;

  assign frame = {shift_q[30:0], serial_write_input};

  // bit counter and shift register, msb first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      count_q <= '0;
    end else if (!enable || select_n) begin
      count_q <= '0; // short frame dropped
    end else if (sclk_rise) begin
      shift_q <= frame;
      if (count_q == 6'(FRAME_BITS - 1)) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + 6'h01;
      end
    end
  end

  // publish after the 32nd bit, header checked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr <= '0;
    end else begin
      wr.valid <= enable && !select_n && sclk_rise && count_q == 6'(FRAME_BITS - 1)
        && frame[31:20] == HDR_PATTERN;
      wr.addr <= frame[19:16];
      wr.data <= frame[15:0];
    end
  end

endmodule

// ### hw/scw_top.sv
// Purpose: serial configuration write port with its eight write-only registers
// Assumes: host link pins are asynchronous; CORE_CLK far faster than the serial clock
// Notes: registers steer outputs only in extended control mode
// Notes: a select release or mode change mid-frame clears the bit count and loses the frame
// Notes: the serial clock half period must exceed one core cycle to be seen
// Notes: must-be-one bits are stored as sent; keeping them right is the host's job
// Notes on behaviour
// - serial writes accepted only in extended control mode
// - data sampled on each rising serial clock edge
// - one access is exactly 32 bits, msb first
// - frame starts with header eleven zeros then a one
// - four address bits then sixteen data bits
// - address bit 3 follows header, bit 0 comes last
// - next frame may start on the 33rd serial clock
// - address decode for the eight registers, others reserved
// - register values ignored in normal control mode
// - configuration register resets to 0xb2ff, write-only
// - config bit 12 enables duty cycle stabilizer
// - config bit 11 sets ddr output clock phase
// - config bit 10 selects single rate when one
// - config bit 9 selects normal output swing when one
// - config bit 8 picks single rate output edge
// - offset register: magnitude 15:8, sign bit 7, reset zero
// - gain register: 9-bit value 15:7, reset midscale
// - gain change applies without recalibration
`timescale 1ns/1ps
module scw_top
  import scw_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_WRITE_INPUT,
  input wire logic SERIAL_SELECT_N,
  input wire logic CONTROL_MODE_PIN,
  input wire logic EDGE_SELECT_PIN,
  input wire logic SWING_SELECT_PIN,
  input wire logic SINGLE_RATE_PIN,
  output logic EXTENDED_MODE,
  output logic DUTY_CYCLE_STABILIZE,
  output logic DDR_OUTPUT_PHASE,
  output logic SINGLE_RATE_SELECT,
  output logic OUTPUT_SWING_SELECT,
  output logic EDGE_SELECT,
  output logic [7:0] I_OFFSET_MAG,
  output logic I_OFFSET_NEG,
  output logic [8:0] I_GAIN,
  output logic [7:0] Q_OFFSET_MAG,
  output logic Q_OFFSET_NEG,
  output logic [8:0] Q_GAIN,
  output logic INTERLEAVE_EN,
  output logic INTERLEAVE_AUTO_PHASE,
  output logic INTERLEAVE_INPUT_Q,
  output logic INTERLEAVE_DELAY_Q,
  output logic [2:0] INTERLEAVE_COARSE,
  output logic [8:0] INTERLEAVE_FINE,
  output logic WRITE_STROBE,
  output logic [3:0] WRITE_ADDR
);

  logic [6:0] pins_s;
  logic sclk_s, serial_write_input_s, sel_n_s, mode_s, edge_pin_s, swing_pin_s, sdr_pin_s;
  logic sclk_prev_q;
  logic sclk_rise;
  logic ext_mode_q;
  scw_write_s wr;
  logic [15:0] cfg_q, iofs_q, igain_q, qofs_q, qgain_q, ilv_en_q, ilv_crs_q, ilv_fine_q;
  scw_outctl_s ctl;

  // true when a code names a real register
  function automatic logic is_mapped(input logic [3:0] a);
    case (a)
      ADDR_CONFIG, ADDR_I_OFFSET, ADDR_I_GAIN, ADDR_Q_OFFSET, ADDR_Q_GAIN,
      ADDR_ILV_ENABLE, ADDR_ILV_COARSE, ADDR_ILV_FINE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // write enable for one register code
  function automatic logic hit(input scw_write_s w, input logic [3:0] a);
    hit = w.valid && w.addr == a;
  endfunction

  // offset trim as magnitude then sign, neutral outside extended mode
  function automatic logic [8:0] offset_trim(input logic ext, input logic [15:0] w);
    if (ext) begin
      offset_trim = {w[15:OFS_MAG_LSB], w[OFS_SIGN_BIT]};
    end else begin
      offset_trim = {RST_OFFSET[15:OFS_MAG_LSB], 1'b0};
    end
  endfunction

  // gain trim, midscale outside extended mode
  function automatic logic [8:0] gain_trim(input logic ext, input logic [15:0] w);
    if (ext) begin
      gain_trim = w[15:GAIN_LSB];
    end else begin
      gain_trim = RST_GAIN[15:GAIN_LSB];
    end
  endfunction

  // every pin but CORE_CLK and RESET passes two flops before use
  scw_sync #(.WIDTH(7)) u_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .din({SERIAL_CLK, SERIAL_WRITE_INPUT, SERIAL_SELECT_N, CONTROL_MODE_PIN,
          EDGE_SELECT_PIN, SWING_SELECT_PIN, SINGLE_RATE_PIN}),
    .dout(pins_s)
  );
  assign {sclk_s, serial_write_input_s, sel_n_s, mode_s, edge_pin_s, swing_pin_s, sdr_pin_s} = pins_s;

  // prev resets low like the idle serial clock, so reset gives no false edge
  // serial clock edge finder, on synchronised level only
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s && !sclk_prev_q;

  // a change mid-frame disables the shifter and the frame is lost
  // mode pin assumed static; a plain registered copy suffices
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ext_mode_q <= 1'b0;
    end else begin
      ext_mode_q <= mode_s;
    end
  end

  // frame shifter, idle outside extended mode
  scw_shifter u_shift (
    .clk(CORE_CLK),
    .rst(RESET),
    .enable(ext_mode_q),
    .select_n(sel_n_s),
    .sclk_rise(sclk_rise),
    .serial_write_input(serial_write_input_s),
    .wr(wr)
  );

  // configuration register
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cfg_q <= RST_CONFIG;
    end else if (hit(wr, ADDR_CONFIG)) begin
      cfg_q <= wr.data;
    end
  end

  // channel offset registers
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      iofs_q <= RST_OFFSET;
      qofs_q <= RST_OFFSET;
    end else begin
      if (hit(wr, ADDR_I_OFFSET)) begin
        iofs_q <= wr.data;
      end
      if (hit(wr, ADDR_Q_OFFSET)) begin
        qofs_q <= wr.data;
      end
    end
  end

  // gain registers apply immediately, no recalibration hook
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      igain_q <= RST_GAIN;
      qgain_q <= RST_GAIN;
    end else begin
      if (hit(wr, ADDR_I_GAIN)) begin
        igain_q <= wr.data;
      end
      if (hit(wr, ADDR_Q_GAIN)) begin
        qgain_q <= wr.data;
      end
    end
  end

  // interleave registers
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ilv_en_q <= RST_ILV_ENABLE;
      ilv_crs_q <= RST_ILV_COARSE;
      ilv_fine_q <= RST_ILV_FINE;
    end else begin
      if (hit(wr, ADDR_ILV_ENABLE)) begin
        ilv_en_q <= wr.data;
      end
      if (hit(wr, ADDR_ILV_COARSE)) begin
        ilv_crs_q <= wr.data;
      end
      if (hit(wr, ADDR_ILV_FINE)) begin
        ilv_fine_q <= wr.data;
      end
    end
  end

  // effective controls: pins for single rate, swing and edge in normal mode, register fields in extended mode
  always_comb begin
    if (ext_mode_q) begin
      ctl.duty_cycle_stabilize = cfg_q[CFG_DCS_BIT];
      ctl.ddr_output_phase = cfg_q[CFG_DCP_BIT] && !cfg_q[CFG_SDR_BIT];
      ctl.single_rate_select = cfg_q[CFG_SDR_BIT];
      ctl.output_swing_select = cfg_q[CFG_SWING_BIT];
      ctl.edge_select = cfg_q[CFG_EDGE_BIT];
    end else begin
      ctl.duty_cycle_stabilize = RST_CONFIG[CFG_DCS_BIT];
      ctl.ddr_output_phase = 1'b0;
      ctl.single_rate_select = sdr_pin_s;
      ctl.output_swing_select = swing_pin_s;
      ctl.edge_select = edge_pin_s;
    end
  end

  // registered outputs; reset presents power-on values
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      DUTY_CYCLE_STABILIZE <= RST_CONFIG[CFG_DCS_BIT];
      DDR_OUTPUT_PHASE <= 1'b0;
      SINGLE_RATE_SELECT <= 1'b0;
      OUTPUT_SWING_SELECT <= RST_CONFIG[CFG_SWING_BIT];
      EDGE_SELECT <= 1'b0;
    end else begin
      {DUTY_CYCLE_STABILIZE, DDR_OUTPUT_PHASE, SINGLE_RATE_SELECT,
       OUTPUT_SWING_SELECT, EDGE_SELECT} <= ctl;
    end
  end

  // mode indication, on the same edge as the controls it qualifies
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      EXTENDED_MODE <= 1'b0;
    end else begin
      EXTENDED_MODE <= ext_mode_q;
    end
  end

  // i channel trim outputs, gated to neutral in normal mode
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      {I_OFFSET_MAG, I_OFFSET_NEG} <= {RST_OFFSET[15:OFS_MAG_LSB], 1'b0};
      I_GAIN <= RST_GAIN[15:GAIN_LSB];
    end else begin
      {I_OFFSET_MAG, I_OFFSET_NEG} <= offset_trim(ext_mode_q, iofs_q);
      I_GAIN <= gain_trim(ext_mode_q, igain_q);
    end
  end

  // q channel trim outputs, same field layout as the i channel
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      {Q_OFFSET_MAG, Q_OFFSET_NEG} <= {RST_OFFSET[15:OFS_MAG_LSB], 1'b0};
      Q_GAIN <= RST_GAIN[15:GAIN_LSB];
    end else begin
      {Q_OFFSET_MAG, Q_OFFSET_NEG} <= offset_trim(ext_mode_q, qofs_q);
      Q_GAIN <= gain_trim(ext_mode_q, qgain_q);
    end
  end

  // interleave outputs; normal mode leaves interleave off here
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      INTERLEAVE_EN <= 1'b0;
      INTERLEAVE_AUTO_PHASE <= 1'b0;
      INTERLEAVE_INPUT_Q <= 1'b0;
      INTERLEAVE_DELAY_Q <= 1'b0;
      INTERLEAVE_COARSE <= '0;
      INTERLEAVE_FINE <= '0;
    end else begin
      INTERLEAVE_EN <= ext_mode_q && ilv_en_q[ILV_EN_BIT];
      INTERLEAVE_AUTO_PHASE <= ext_mode_q && ilv_en_q[ILV_AUTO_BIT];
      INTERLEAVE_INPUT_Q <= ext_mode_q && ilv_crs_q[CRS_INSEL_BIT];
      INTERLEAVE_DELAY_Q <= ext_mode_q && ilv_crs_q[CRS_DIR_BIT];
      INTERLEAVE_COARSE <= ext_mode_q ? ilv_crs_q[13:CRS_MAG_LSB] : 3'h0;
      INTERLEAVE_FINE <= ext_mode_q ? ilv_fine_q[15:FINE_LSB] : 9'h000;
    end
  end

  // reserved codes still finish their frame but raise no strobe
  // write indication for observers, mapped codes only
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      WRITE_STROBE <= 1'b0;
      WRITE_ADDR <= '0;
    end else begin
      WRITE_STROBE <= wr.valid && is_mapped(wr.addr);
      WRITE_ADDR <= wr.addr;
    end
  end

endmodule

// ### test/scw_top_properties.sv
// Purpose: port-level assertions for the serial write port
// Assumes: mode pin only moves while the link is idle
// Notes: bound to scw_top after the module
`timescale 1ns/1ps
module scw_top_checker
  import scw_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic SERIAL_SELECT_N,
  input wire logic CONTROL_MODE_PIN,
  input wire logic EXTENDED_MODE,
  input wire logic DUTY_CYCLE_STABILIZE,
  input wire logic DDR_OUTPUT_PHASE,
  input wire logic SINGLE_RATE_SELECT,
  input wire logic [8:0] I_GAIN,
  input wire logic [8:0] Q_GAIN,
  input wire logic INTERLEAVE_EN,
  input wire logic [8:0] INTERLEAVE_FINE,
  input wire logic WRITE_STROBE,
  input wire logic [3:0] WRITE_ADDR
);
  logic [2:0] since_q;
  // cycles since reset, the sync chain still holds reset values early on
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) since_q <= 3'h0;
    else if (since_q != 3'h7) since_q <= since_q + 3'h1;
  end
  default clocking dcb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  chk_strobe_gap: assert property (WRITE_STROBE |=> !WRITE_STROBE [*8])
    else $error("strobe too soon");
  chk_strobe_mode: assert property (WRITE_STROBE |-> EXTENDED_MODE)
    else $error("write in normal mode");
  chk_strobe_map: assert property (WRITE_STROBE |-> WRITE_ADDR inside {[1:3], [10:11], [13:15]})
    else $error("strobe for reserved code");
  chk_strobe_sel: assert property (WRITE_STROBE |-> !$past(SERIAL_SELECT_N, 5))
    else $error("strobe without select");
  chk_normal_idle: assert property (!EXTENDED_MODE [*3] |->
    I_GAIN == 9'h100 && Q_GAIN == 9'h100 && !INTERLEAVE_EN && DUTY_CYCLE_STABILIZE && !DDR_OUTPUT_PHASE)
    else $error("trim active in normal mode");
  chk_trim_hold: assert property ((!WRITE_STROBE && $stable(EXTENDED_MODE)) [*2] |->
    $stable(I_GAIN) && $stable(Q_GAIN) && $stable(INTERLEAVE_FINE))
    else $error("trim moved without write");
  chk_ddr_phase: assert property (DDR_OUTPUT_PHASE |-> !SINGLE_RATE_SELECT)
    else $error("ddr phase in single rate");
  chk_mode_follow: assert property ((since_q == 3'h7 && $stable(CONTROL_MODE_PIN)) [*4] |->
    EXTENDED_MODE == CONTROL_MODE_PIN)
    else $error("mode not followed");
  cov_cfg: cover property (WRITE_STROBE && WRITE_ADDR == ADDR_CONFIG);
  cov_fine: cover property (WRITE_STROBE && WRITE_ADDR == ADDR_ILV_FINE);
  cov_normal: cover property (!EXTENDED_MODE [*3]);
endmodule

bind scw_top scw_top_checker scw_top_checker_inst (.CORE_CLK, .RESET, .SERIAL_SELECT_N, .CONTROL_MODE_PIN,
  .EXTENDED_MODE, .DUTY_CYCLE_STABILIZE, .DDR_OUTPUT_PHASE, .SINGLE_RATE_SELECT, .I_GAIN, .Q_GAIN,
  .INTERLEAVE_EN, .INTERLEAVE_FINE, .WRITE_STROBE, .WRITE_ADDR);

// ### test/scw_host.sv
// Purpose: host model driving the serial write link
// Assumes: 80 ns serial clock, idle low between frames
// Notes: offset start keeps pin edges off core edges
`timescale 1ns/1ps
module scw_host (
  output logic SERIAL_CLK,
  output logic SERIAL_WRITE_INPUT,
  output logic SERIAL_SELECT_N
);
  initial begin
    SERIAL_CLK = 1'b0;
    SERIAL_WRITE_INPUT = 1'b1;
    SERIAL_SELECT_N = 1'b1;
  end
  // n bits msb first; hold keeps select low for a following frame
  task automatic send(input logic [31:0] f, input int n, input bit hold);
    #1.3;
    SERIAL_SELECT_N = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      SERIAL_WRITE_INPUT = f[i];
      #40 SERIAL_CLK = 1'b1;
      #40 SERIAL_CLK = 1'b0;
    end
    if (!hold) begin
      SERIAL_SELECT_N = 1'b1;
      SERIAL_WRITE_INPUT = ~SERIAL_WRITE_INPUT; // released line no longer shows data
    end
  endtask
endmodule

// ### test/tb.sv
// Purpose: self-checking bench for the serial write port
// Assumes: host model drives the link, bench drives pins and reset
// Notes: table rows first, then framing, mode and reset cases
`timescale 1ns/1ps
module tb
  import scw_pkg::*;
;
  typedef struct {logic [3:0] a; logic [15:0] d; logic [15:0] e; logic [15:0] r;} scw_row_s;
  logic CORE_CLK, RESET, CONTROL_MODE_PIN, EDGE_SELECT_PIN, SWING_SELECT_PIN, SINGLE_RATE_PIN;
  logic SERIAL_CLK, SERIAL_WRITE_INPUT, SERIAL_SELECT_N, EXTENDED_MODE, DUTY_CYCLE_STABILIZE;
  logic DDR_OUTPUT_PHASE, SINGLE_RATE_SELECT, OUTPUT_SWING_SELECT, EDGE_SELECT, I_OFFSET_NEG;
  logic Q_OFFSET_NEG, INTERLEAVE_EN, INTERLEAVE_AUTO_PHASE, INTERLEAVE_INPUT_Q, INTERLEAVE_DELAY_Q;
  logic WRITE_STROBE;
  logic [7:0] I_OFFSET_MAG, Q_OFFSET_MAG;
  logic [8:0] I_GAIN, Q_GAIN, INTERLEAVE_FINE;
  logic [2:0] INTERLEAVE_COARSE;
  logic [3:0] WRITE_ADDR, last_addr;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_strobe = 0;
  int base;
  // address, data sent, field seen, power-on field
  scw_row_s rows [9] = '{'{ADDR_CONFIG, 16'ha9ff, 16'h0009, 16'h0012},
    '{ADDR_CONFIG, 16'hbeff, 16'h0016, 16'h0012}, '{ADDR_I_OFFSET, 16'ha5ff, 16'h014b, 16'h0000},
    '{ADDR_I_GAIN, 16'he07f, 16'h01c0, 16'h0100}, '{ADDR_Q_OFFSET, 16'h3c7f, 16'h0078, 16'h0000},
    '{ADDR_Q_GAIN, 16'h607f, 16'h00c0, 16'h0100}, '{ADDR_ILV_ENABLE, 16'hbfff, 16'h0002, 16'h0000},
    '{ADDR_ILV_COARSE, 16'h67ff, 16'h000c, 16'h0000}, '{ADDR_ILV_FINE, 16'hff7f, 16'h01fe, 16'h0000}};
  logic [3:0] rsv [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc};

  scw_top scw_top_inst (.CORE_CLK, .RESET, .SERIAL_CLK, .SERIAL_WRITE_INPUT, .SERIAL_SELECT_N,
    .CONTROL_MODE_PIN, .EDGE_SELECT_PIN, .SWING_SELECT_PIN, .SINGLE_RATE_PIN, .EXTENDED_MODE,
    .DUTY_CYCLE_STABILIZE, .DDR_OUTPUT_PHASE, .SINGLE_RATE_SELECT, .OUTPUT_SWING_SELECT, .EDGE_SELECT,
    .I_OFFSET_MAG, .I_OFFSET_NEG, .I_GAIN, .Q_OFFSET_MAG, .Q_OFFSET_NEG, .Q_GAIN, .INTERLEAVE_EN,
    .INTERLEAVE_AUTO_PHASE, .INTERLEAVE_INPUT_Q, .INTERLEAVE_DELAY_Q, .INTERLEAVE_COARSE,
    .INTERLEAVE_FINE, .WRITE_STROBE, .WRITE_ADDR);
  scw_host scw_host_inst (.SERIAL_CLK, .SERIAL_WRITE_INPUT, .SERIAL_SELECT_N);

  // header, address then data, all msb first
  function automatic logic [31:0] frame(input logic [3:0] a, input logic [15:0] d);
    frame = {HDR_PATTERN, a, d};
  endfunction

  // output group belonging to one register code
  function automatic logic [15:0] obs(input logic [3:0] a);
    case (a)
      ADDR_CONFIG: obs = {11'h0, DUTY_CYCLE_STABILIZE, DDR_OUTPUT_PHASE, SINGLE_RATE_SELECT,
        OUTPUT_SWING_SELECT, EDGE_SELECT};
      ADDR_I_OFFSET: obs = {7'h0, I_OFFSET_MAG, I_OFFSET_NEG};
      ADDR_I_GAIN: obs = {7'h0, I_GAIN};
      ADDR_Q_OFFSET: obs = {7'h0, Q_OFFSET_MAG, Q_OFFSET_NEG};
      ADDR_Q_GAIN: obs = {7'h0, Q_GAIN};
      ADDR_ILV_ENABLE: obs = {14'h0, INTERLEAVE_EN, INTERLEAVE_AUTO_PHASE};
      ADDR_ILV_COARSE: obs = {11'h0, INTERLEAVE_INPUT_Q, INTERLEAVE_DELAY_Q, INTERLEAVE_COARSE};
      default: obs = {7'h0, INTERLEAVE_FINE};
    endcase
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  // strobe count and address, plus a hang limit
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (WRITE_STROBE === 1'b1) begin
      n_strobe <= n_strobe + 1;
      last_addr <= WRITE_ADDR;
    end
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    RESET = 1'b1;
    CONTROL_MODE_PIN = 1'b1;
    EDGE_SELECT_PIN = 1'b0;
    SWING_SELECT_PIN = 1'b1;
    SINGLE_RATE_PIN = 1'b0;
    repeat (10) @(posedge CORE_CLK);
    RESET <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    // rows go back to back with select held low
    foreach (rows[i]) begin
      scw_host_inst.send(frame(rows[i].a, rows[i].d), 32, 1'b1);
      check("field", rows[i].e, obs(rows[i].a));
      check("strobes", 16'(i + 1), 16'(n_strobe));
      check("addr", {12'h0, rows[i].a}, {12'h0, last_addr});
    end
    check("mode", 16'h0001, {15'h0, EXTENDED_MODE});
    // broken header still costs 32 bits, then the link resyncs
    base = n_strobe;
    scw_host_inst.send({12'h002, ADDR_I_GAIN, 16'h007f}, 32, 1'b1);
    check("bad header", 16'h01c0, obs(ADDR_I_GAIN));
    scw_host_inst.send(frame(ADDR_I_GAIN, 16'h807f), 32, 1'b1);
    check("resync", 16'h0100, obs(ADDR_I_GAIN));
    // reserved codes, then a frame cut short by select
    foreach (rsv[i]) scw_host_inst.send(frame(rsv[i], 16'h0000), 32, 1'b1);
    scw_host_inst.send(frame(ADDR_I_OFFSET, 16'h007f), 20, 1'b0);
    check("cut frame", 16'h014b, obs(ADDR_I_OFFSET));
    check("reserved", 16'h0016, obs(ADDR_CONFIG));
    check("strobes", 16'(base + 1), 16'(n_strobe));
    // normal mode: pins rule, writes ignored, registers kept; mode moves only while the link is idle
    @(posedge CORE_CLK);
    CONTROL_MODE_PIN <= 1'b0;
    SWING_SELECT_PIN <= 1'b0;
    EDGE_SELECT_PIN <= 1'b1;
    SINGLE_RATE_PIN <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    check("normal mode", 16'h0000, {15'h0, EXTENDED_MODE});
    check("normal cfg", 16'h0015, obs(ADDR_CONFIG));
    check("normal gain", 16'h0100, obs(ADDR_Q_GAIN));
    scw_host_inst.send(frame(ADDR_I_GAIN, 16'h007f), 32, 1'b0);
    @(posedge CORE_CLK);
    CONTROL_MODE_PIN <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    check("normal write", 16'h0100, obs(ADDR_I_GAIN));
    check("kept gain", 16'h00c0, obs(ADDR_Q_GAIN));
    check("strobes", 16'(base + 1), 16'(n_strobe));
    // second reset restores power-on values
    RESET <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    foreach (rows[i]) check("reset", rows[i].r, obs(rows[i].a));
    tally_and_finish();
  end
endmodule
